/* logic/arseq_pkg.sv */
/*
  Package for the auto reclose sequencer: register map, field layout,
  reset values, tick and timing constants and the state encoding.
  Assumes a 125 MHz system clock.
*/
`default_nettype none

package arseq_pkg;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_HZ         = 125000000;
  localparam int unsigned TICK_US        = 1000;
  localparam int unsigned TICK_CYC       = CLK_HZ / 1000000 * TICK_US;
  localparam int unsigned LOCKOUT_MS     = 500;
  localparam int unsigned LOCKOUT_TICKS  = LOCKOUT_MS * 1000 / TICK_US;
  localparam int unsigned NCYC           = 4;

  // ------------------------------------------------------------
  // register offsets (byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_STATUS  = 8'h04;
  localparam logic [7:0] OFS_RECLAIM = 8'h08;
  localparam logic [7:0] OFS_MCBLK   = 8'h0C;
  localparam logic [7:0] OFS_ACT0    = 8'h10;
  localparam logic [7:0] OFS_DEAD0   = 8'h20;
  localparam logic [7:0] OFS_CYCLE_STRIDE = 8'h20;

  // ctrl fields
  localparam int unsigned CTRL_ENABLE   = 0;
  localparam int unsigned CTRL_PICKUP   = 1;
  localparam int unsigned CTRL_ADAPTIVE = 2;
  localparam int unsigned CTRL_USE_ACT  = 3;
  localparam int unsigned CTRL_NCYC_LSB = 4;
  localparam int unsigned CTRL_START_LSB = 8;
  localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;

  // ------------------------------------------------------------
  // states
  // ------------------------------------------------------------
  typedef enum logic [5:0] {
    ST_IDLE    = 6'h01,
    ST_ACTION  = 6'h02,
    ST_TRIPPED = 6'h04,
    ST_DEAD    = 6'h08,
    ST_RECLAIM = 6'h10,
    ST_LOCKOUT = 6'h20
  } arseq_state_e;

endpackage

`default_nettype wire

/* logic/arseq_tick.sv */
/*
  Periodic tick generator: one-cycle enable every DIV clocks.
  Assumes a single system clock and asynchronous low reset.
*/
`timescale 1ns/1ps
`default_nettype none

module arseq_tick #(
  parameter int unsigned DIV = arseq_pkg::TICK_CYC
) (
  input  wire logic clk_sys,
  input  wire logic resetn,
  output var  logic tick
);

  logic [19:0] cnt_q;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= 20'h0_0000;
      tick  <= 1'b0;
    end else if (cnt_q == 20'(DIV - 1)) begin
      cnt_q <= 20'h0_0000;
      tick  <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 20'h0_0001;
      tick  <= 1'b0;
    end
  end

endmodule // arseq_tick

`default_nettype wire

/* logic/arseq_core.sv */
/*
  Auto reclose sequencer core with Avalon-MM register slave.
  Assumes protection inputs synchronous to clk_sys; timers count ticks.
*/
`timescale 1ns/1ps
`default_nettype none

module arseq_core #(
  parameter int unsigned NCYC    = arseq_pkg::NCYC,
  parameter int unsigned TICKDIV = arseq_pkg::TICK_CYC
) (
  input  wire logic            clk_sys,
  input  wire logic            resetn,
  input  wire logic [7:0]      avs_address,
  input  wire logic            avs_read,
  input  wire logic            avs_write,
  input  wire logic [31:0]     avs_writedata,
  output var  logic [31:0]     avs_readdata,
  output logic                 avs_waitrequest,
  input  wire logic            pickup_gen,
  input  wire logic [2:0]      pickup_phase,
  input  wire logic            trip_cmd,
  input  wire logic            trip_3pole,
  input  wire logic            cb_open,
  input  wire logic            cb_ready,
  input  wire logic            manual_close,
  input  wire logic            block_all,
  input  wire logic [NCYC-1:0] block_cycle,
  output var  logic            close_cmd,
  output var  logic            lockout_active,
  output var  logic            reclose_busy
);

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [31:0] ctrl_q;
  logic [15:0] reclaim_block_time_q;
  logic [15:0] manual_close_block_time_q;
  logic [15:0] act_q  [NCYC];
  logic [15:0] dead_q [NCYC][4]; // 1p/1ph, 2ph, 3p/3ph
  logic        ack_q;
  logic        last_fail_q;

  arseq_pkg::arseq_state_e state_q;
  logic [1:0]  cyc_q;
  logic [15:0] tmr_q;
  logic [15:0] act_tmr_q;
  logic [15:0] mc_tmr_q;
  logic        tick;
  logic        trip_q;
  logic        started_q;

  wire logic       enable    = ctrl_q[arseq_pkg::CTRL_ENABLE];
  wire logic       pick_mode = ctrl_q[arseq_pkg::CTRL_PICKUP];
  wire logic       adaptive  = ctrl_q[arseq_pkg::CTRL_ADAPTIVE];
  wire logic       use_act   = ctrl_q[arseq_pkg::CTRL_USE_ACT];
  wire logic [1:0] ncfg      = ctrl_q[arseq_pkg::CTRL_NCYC_LSB +: 2];
  wire logic [NCYC-1:0] start_ok = ctrl_q[arseq_pkg::CTRL_START_LSB +: NCYC];

  // ------------------------------------------------------------
  // tick
  // ------------------------------------------------------------
  arseq_tick #(.DIV(TICKDIV)) u_tick (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .tick    (tick)
  );

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // first valid cycle at or after 'from' whose action window is open
  function automatic logic [2:0] pick_cycle(input logic [2:0] from, input logic first);
    logic [2:0] r;
    r = 3'h4;
    for (int i = NCYC - 1; i >= 0; i--) begin
      if (i >= from && i <= ncfg && !block_cycle[i] && (!first || start_ok[i]) &&
          (!use_act || act_tmr_q < act_q[i]))
        r = 3'(i);
    end
    return r;
  endfunction

  function automatic logic [1:0] dead_sel(input logic pm, input logic t3, input logic [2:0] ph);
    logic [1:0] s;
    s = 2'h0;
    if (pm) begin
      case (ph)
        3'h7:                      s = 2'h2;
        3'h3, 3'h5, 3'h6:          s = 2'h1;
        default:                   s = 2'h0;
      endcase
    end else begin
      s = t3 ? 2'h2 : 2'h0;
    end
    return s;
  endfunction

  // ------------------------------------------------------------
  // avalon slave: one wait cycle on every access
  // ------------------------------------------------------------
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (avs_read | avs_write) & ~ack_q;
    end
  end

  wire logic wr_go = avs_write & ack_q;
  wire logic [2:0] a_cyc = avs_address[7:5] - 3'h1;
  wire logic [1:0] a_sel = avs_address[3:2];

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ctrl_q                    <= arseq_pkg::CTRL_RESET;
      reclaim_block_time_q      <= 16'h0000;
      manual_close_block_time_q <= 16'h0000;
      for (int i = 0; i < NCYC; i++) begin
        act_q[i] <= 16'h0000;
        for (int j = 0; j < 4; j++) dead_q[i][j] <= 16'h0000;
      end
    end else if (wr_go) begin
      case (avs_address)
        arseq_pkg::OFS_CTRL:    ctrl_q <= avs_writedata;
        arseq_pkg::OFS_RECLAIM: reclaim_block_time_q <= avs_writedata[15:0];
        arseq_pkg::OFS_MCBLK:   manual_close_block_time_q <= avs_writedata[15:0];
        default: begin
          if (avs_address >= arseq_pkg::OFS_ACT0 && avs_address < arseq_pkg::OFS_DEAD0 &&
              32'(avs_address[3:2]) < NCYC)
            act_q[avs_address[3:2]] <= avs_writedata[15:0];
          else if (avs_address >= arseq_pkg::OFS_DEAD0 && a_cyc < 3'(NCYC) &&
                   avs_address[4] == 1'b0)
            dead_q[a_cyc[1:0]][a_sel] <= avs_writedata[15:0];
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read & ~ack_q) begin
      case (avs_address)
        arseq_pkg::OFS_CTRL:    avs_readdata <= ctrl_q;
        arseq_pkg::OFS_STATUS:  avs_readdata <= {22'h00_0000, last_fail_q, started_q,
                                                 cyc_q, 6'(state_q)};
        arseq_pkg::OFS_RECLAIM: avs_readdata <= {16'h0000, reclaim_block_time_q};
        arseq_pkg::OFS_MCBLK:   avs_readdata <= {16'h0000, manual_close_block_time_q};
        default: begin
          if (avs_address >= arseq_pkg::OFS_ACT0 && avs_address < arseq_pkg::OFS_DEAD0 &&
              32'(avs_address[3:2]) < NCYC)
            avs_readdata <= {16'h0000, act_q[avs_address[3:2]]};
          else if (avs_address >= arseq_pkg::OFS_DEAD0 && a_cyc < 3'(NCYC) &&
                   avs_address[4] == 1'b0)
            avs_readdata <= {16'h0000, dead_q[a_cyc[1:0]][a_sel]};
          else
            avs_readdata <= 32'h0000_0000;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // action and manual close timers
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      act_tmr_q <= 16'h0000;
    end else if (!pickup_gen && state_q != arseq_pkg::ST_ACTION) begin
      act_tmr_q <= 16'h0000;
    end else if (tick && act_tmr_q != 16'hFFFF) begin
      act_tmr_q <= act_tmr_q + 16'h0001;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      mc_tmr_q <= 16'h0000;
    end else if (manual_close) begin
      mc_tmr_q <= manual_close_block_time_q;
    end else if (tick && mc_tmr_q != 16'h0000) begin
      mc_tmr_q <= mc_tmr_q - 16'h0001;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) trip_q <= 1'b0;
    else         trip_q <= trip_cmd;
  end

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  wire logic trip_rise = trip_cmd & ~trip_q;
  wire logic mc_block  = mc_tmr_q != 16'h0000 || manual_close;
  logic [2:0] first_pick;
  logic [2:0] next_pick;

  // function reads timers and settings; always_comb keeps it live
  always_comb begin
    first_pick = pick_cycle(3'h0, 1'b1);
    next_pick  = pick_cycle(3'(cyc_q) + 3'h1, 1'b0);
  end
  wire logic reclaim_off = adaptive && reclaim_block_time_q == 16'h0000;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_q     <= arseq_pkg::ST_IDLE;
      cyc_q       <= 2'h0;
      tmr_q       <= 16'h0000;
      close_cmd   <= 1'b0;
      started_q   <= 1'b0;
      last_fail_q <= 1'b0;
    end else begin
      close_cmd <= 1'b0;
      case (state_q)
        arseq_pkg::ST_IDLE: begin
          started_q <= 1'b0;
          if (enable && !block_all && pickup_gen)
            state_q <= arseq_pkg::ST_ACTION;
        end
        arseq_pkg::ST_ACTION: begin
          if (!pickup_gen && !trip_cmd) begin
            state_q <= arseq_pkg::ST_IDLE;
          end else if (trip_rise) begin
            if (block_all || mc_block || !cb_ready || first_pick[2]) begin
              state_q <= arseq_pkg::ST_IDLE;
            end else begin
              cyc_q     <= first_pick[1:0];
              started_q <= 1'b1;
              state_q   <= arseq_pkg::ST_TRIPPED;
            end
          end
        end
        arseq_pkg::ST_TRIPPED: begin
          if (block_all || block_cycle[cyc_q]) begin
            state_q <= arseq_pkg::ST_LOCKOUT;
            tmr_q   <= 16'(arseq_pkg::LOCKOUT_TICKS);
          end else if (!trip_cmd && (cb_open || !trip_q)) begin
            tmr_q   <= dead_q[cyc_q][dead_sel(pick_mode, trip_3pole, pickup_phase)];
            state_q <= arseq_pkg::ST_DEAD;
          end
        end
        arseq_pkg::ST_DEAD: begin
          if (block_all || block_cycle[cyc_q]) begin
            state_q <= arseq_pkg::ST_LOCKOUT;
            tmr_q   <= 16'(arseq_pkg::LOCKOUT_TICKS);
          end else if (tmr_q == 16'h0000) begin
            close_cmd <= 1'b1;
            tmr_q     <= reclaim_block_time_q;
            state_q   <= reclaim_off ? arseq_pkg::ST_IDLE : arseq_pkg::ST_RECLAIM;
          end else if (tick) begin
            tmr_q <= tmr_q - 16'h0001;
          end
        end
        arseq_pkg::ST_RECLAIM: begin
          if (block_all) begin
            state_q <= arseq_pkg::ST_LOCKOUT;
            tmr_q   <= 16'(arseq_pkg::LOCKOUT_TICKS);
          end else if (trip_rise) begin
            if (!mc_block && !next_pick[2]) begin
              cyc_q   <= next_pick[1:0];
              state_q <= arseq_pkg::ST_TRIPPED;
            end else begin
              last_fail_q <= 1'b1;
              state_q     <= arseq_pkg::ST_LOCKOUT;
              tmr_q       <= 16'(arseq_pkg::LOCKOUT_TICKS);
            end
          end else if (tmr_q == 16'h0000) begin
            last_fail_q <= 1'b0;
            state_q     <= arseq_pkg::ST_IDLE;
          end else if (tick) begin
            tmr_q <= tmr_q - 16'h0001;
          end
        end
        arseq_pkg::ST_LOCKOUT: begin
          if (tmr_q == 16'h0000)
            state_q <= arseq_pkg::ST_IDLE;
          else if (tick)
            tmr_q <= tmr_q - 16'h0001;
        end
        default: state_q <= arseq_pkg::ST_IDLE;
      endcase
    end
  end

  always_comb begin
    lockout_active = state_q == arseq_pkg::ST_LOCKOUT;
    reclose_busy   = state_q != arseq_pkg::ST_IDLE;
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  sequence s_dead_done;
    state_q == arseq_pkg::ST_DEAD && tmr_q == 16'h0000 && !block_all && !block_cycle[cyc_q];
  endsequence

  a_close_after_dead: assert property (s_dead_done |=> close_cmd)
    else $error("close not issued at dead time end");
  a_reclaim_load: assert property (close_cmd && state_q == arseq_pkg::ST_RECLAIM
      |-> tmr_q == reclaim_block_time_q)
    else $error("reclaim timer not loaded on close");
  a_reclaim_zero_adt: assert property ((s_dead_done and reclaim_off)
      |=> state_q == arseq_pkg::ST_IDLE)
    else $error("adaptive zero reclaim did not go idle");
  a_reclaim_expiry: assert property (state_q == arseq_pkg::ST_RECLAIM && tmr_q == 16'h0000
      && !trip_rise && !block_all |=> state_q == arseq_pkg::ST_IDLE)
    else $error("reclaim expiry not idle");
  a_global_block_idle: assert property (state_q == arseq_pkg::ST_IDLE && block_all
      |=> state_q == arseq_pkg::ST_IDLE)
    else $error("start despite global block");
  a_cycle_abort: assert property (state_q == arseq_pkg::ST_DEAD && block_cycle[cyc_q]
      |=> state_q == arseq_pkg::ST_LOCKOUT && tmr_q == 16'(arseq_pkg::LOCKOUT_TICKS))
    else $error("running cycle block did not abort");
  a_lockout_end: assert property (lockout_active && tmr_q == 16'h0000
      |=> state_q == arseq_pkg::ST_IDLE)
    else $error("lock-out expiry not idle");
  a_no_ready_no_start: assert property (state_q == arseq_pkg::ST_ACTION && trip_rise
      && !cb_ready |=> !started_q)
    else $error("start without breaker ready");
  a_reclaim_last_trip: assert property (state_q == arseq_pkg::ST_RECLAIM && trip_rise
      && !block_all && next_pick[2] |=> lockout_active && last_fail_q)
    else $error("final trip not locked out");
  a_late_first_none: assert property (state_q == arseq_pkg::ST_ACTION && trip_rise
      && first_pick[2] |=> state_q == arseq_pkg::ST_IDLE ##1 !close_cmd)
    else $error("reclose with no permitted cycle");

endmodule // arseq_core

`default_nettype wire

/* testbench/arseq_breaker_model.sv */
/*
  Breaker model facing the reclose sequencer: opens on trip, closes on
  the automatic close pulse. Assumes one clock and a low async reset.
*/
`timescale 1ns/1ps
`default_nettype none

module arseq_breaker_model (
  input  wire logic clk_sys,
  input  wire logic resetn,
  input  wire logic trip_cmd,
  input  wire logic close_cmd,
  input  wire logic ready_en,
  output var  logic cb_open,
  output var  logic cb_ready
);
  logic open_q;

  // ------------------------------------------------------------
  // breaker position
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      open_q <= 1'b0;
    end else if (close_cmd) begin
      open_q <= 1'b0;
    end else if (trip_cmd) begin
      open_q <= 1'b1;
    end
  end

  assign cb_open  = open_q;
  assign cb_ready = ready_en;
endmodule // arseq_breaker_model

`default_nettype wire

/* testbench/auto_reclose_sequencer_tb.sv */
/*
  Self-checking bench for the reclose sequencer core and breaker model.
  Assumes TICKDIV of 4 clocks and the register map of the package.
*/
`timescale 1ns/1ps
`default_nettype none

module auto_reclose_sequencer_tb;
  localparam int TD = 4;
  typedef struct packed {
    logic [31:0] ctrl;
    logic        tp;
    logic [2:0]  ph;
    logic [7:0]  d;
  } arseq_row_s;

  logic        clk_sys = 1'b0;
  logic        resetn = 1'b0;
  logic [7:0]  avs_address = 8'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        pickup_gen = 1'b0;
  logic [2:0]  pickup_phase = 3'h0;
  logic        trip_cmd = 1'b0;
  logic        trip_3pole = 1'b0;
  logic        manual_close = 1'b0;
  logic        block_all = 1'b0;
  logic [3:0]  block_cycle = 4'h0;
  logic        ready_en = 1'b1;
  logic        cb_open, cb_ready, close_cmd, lockout_active, reclose_busy;
  int          failures = 0, checks = 0, cyc = 0, lo_start = 0, lo_len = 0, n;
  logic [31:0] rd;
  arseq_row_s  rows [5] = '{
    '{32'h0000_0101, 1'b0, 3'h1, 8'h05}, '{32'h0000_0101, 1'b1, 3'h7, 8'h0F},
    '{32'h0000_0103, 1'b0, 3'h1, 8'h05}, '{32'h0000_0103, 1'b0, 3'h3, 8'h0A},
    '{32'h0000_0103, 1'b0, 3'h7, 8'h0F}};

  arseq_core #(.NCYC(4), .TICKDIV(TD)) arseq_core_i (.clk_sys(clk_sys), .resetn(resetn),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .pickup_gen(pickup_gen),
    .pickup_phase(pickup_phase), .trip_cmd(trip_cmd), .trip_3pole(trip_3pole),
    .cb_open(cb_open), .cb_ready(cb_ready), .manual_close(manual_close),
    .block_all(block_all), .block_cycle(block_cycle), .close_cmd(close_cmd),
    .lockout_active(lockout_active), .reclose_busy(reclose_busy));
  arseq_breaker_model arseq_breaker_model_i (.clk_sys(clk_sys), .resetn(resetn),
    .trip_cmd(trip_cmd), .close_cmd(close_cmd), .ready_en(ready_en),
    .cb_open(cb_open), .cb_ready(cb_ready));

  // ------------------------------------------------------------
  // clock, timeout, lock-out length
  // ------------------------------------------------------------
  always #4 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 40000) begin
      failures++;
      summarize();
    end
  end
  always @(posedge lockout_active) lo_start = cyc;
  always @(negedge lockout_active) lo_len = cyc - lo_start;

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  function automatic logic [31:0] win(input int v, input int e);
    return {31'h0, (v >= e - 6) && (v <= e + 10)};
  endfunction

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    for (k = 0; k < 20; k++) begin
      @(posedge clk_sys);
      if (avs_waitrequest === 1'b0) break;
    end
    if (k == 20) failures++;
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  // pickup, trip for 8 clocks, then cycles from trip drop to close
  task automatic fault(input int pre, input logic tp, input logic [2:0] ph,
                       input int bat, input logic [3:0] bv);
    int i;
    @(posedge clk_sys);
    pickup_gen <= 1'b1;
    pickup_phase <= ph;
    trip_3pole <= tp;
    repeat (pre) @(posedge clk_sys);
    trip_cmd <= 1'b1;
    repeat (8) @(posedge clk_sys);
    trip_cmd <= 1'b0;
    for (i = 0; i < 400; i++) begin
      @(posedge clk_sys);
      if (i == 2) pickup_gen <= 1'b0;
      if (i == 2) pickup_phase <= 3'h0;
      if (i == bat) block_cycle <= bv;
      @(negedge clk_sys);
      if (close_cmd === 1'b1) break;
    end
    n = i;
    @(posedge clk_sys);
  endtask

  task automatic wait_idle();
    int i;
    for (i = 0; i < 3000; i++) begin
      @(negedge clk_sys);
      if (reclose_busy === 1'b0) break;
    end
    n = i;
    @(posedge clk_sys);
  endtask

  task automatic done(input string s);
    $display("test %s done", s);
  endtask

  task automatic summarize();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clk_sys);
    check({29'h0, close_cmd, lockout_active, reclose_busy}, 32'h0);
    resetn <= 1'b1;
    bus(1'b0, arseq_pkg::OFS_CTRL, 32'h0);
    check(rd, arseq_pkg::CTRL_RESET);
    bus(1'b0, arseq_pkg::OFS_STATUS, 32'h0);
    check(rd, 32'h1);
    bus(1'b0, 8'hFC, 32'h0);
    check(rd, 32'h0);
    bus(1'b1, arseq_pkg::OFS_STATUS, 32'hFF);
    bus(1'b0, arseq_pkg::OFS_STATUS, 32'h0);
    check(rd, 32'h1);
    bus(1'b1, arseq_pkg::OFS_RECLAIM, 32'h14);
    bus(1'b0, arseq_pkg::OFS_RECLAIM, 32'h0);
    check(rd, 32'h14);
    bus(1'b1, 8'h20, 32'h5);
    bus(1'b1, 8'h24, 32'hA);
    bus(1'b1, 8'h28, 32'hF);
    bus(1'b1, 8'h40, 32'h19);
    bus(1'b1, 8'h10, 32'h3);
    bus(1'b1, 8'h14, 32'h32);
    done("reset and registers");
    foreach (rows[r]) begin
      bus(1'b1, arseq_pkg::OFS_CTRL, rows[r].ctrl);
      fault(8, rows[r].tp, rows[r].ph, -1, 4'h0);
      check(win(n, TD * rows[r].d), 32'h1);
      wait_idle();
      check(win(n, TD * 20), 32'h1);
    end
    done("dead times");
    bus(1'b1, arseq_pkg::OFS_CTRL, 32'h0000_0119);
    fault(80, 1'b0, 3'h1, -1, 4'h0);
    check({31'h0, n == 400}, 32'h1);
    wait_idle();
    bus(1'b1, arseq_pkg::OFS_CTRL, 32'h0000_0319);
    fault(80, 1'b0, 3'h1, -1, 4'h0);
    check(win(n, TD * 25), 32'h1);
    wait_idle();
    block_cycle <= 4'h1;
    bus(1'b1, arseq_pkg::OFS_CTRL, 32'h0000_0311);
    fault(8, 1'b0, 3'h1, -1, 4'h0);
    check(win(n, TD * 25), 32'h1);
    block_cycle <= 4'h0;
    wait_idle();
    done("cycle selection");
    bus(1'b1, arseq_pkg::OFS_CTRL, 32'h0000_0101);
    fault(8, 1'b0, 3'h1, 5, 4'h1);
    check({31'h0, n == 400}, 32'h1);
    block_cycle <= 4'h0;
    wait_idle();
    block_all <= 1'b1;
    fault(8, 1'b0, 3'h1, -1, 4'h0);
    check({31'h0, n == 400}, 32'h1);
    block_all <= 1'b0;
    wait_idle();
    ready_en <= 1'b0;
    fault(8, 1'b0, 3'h1, -1, 4'h0);
    check({31'h0, n == 400}, 32'h1);
    ready_en <= 1'b1;
    wait_idle();
    bus(1'b1, arseq_pkg::OFS_MCBLK, 32'h3C);
    manual_close <= 1'b1;
    @(posedge clk_sys);
    manual_close <= 1'b0;
    fault(8, 1'b0, 3'h1, -1, 4'h0);
    check({31'h0, n == 400}, 32'h1);
    wait_idle();
    done("blocking");
    bus(1'b1, arseq_pkg::OFS_CTRL, 32'h0000_0111);
    fault(8, 1'b0, 3'h1, -1, 4'h0);
    check(win(n, TD * 5), 32'h1);
    fault(2, 1'b0, 3'h1, -1, 4'h0);
    check(win(n, TD * 25), 32'h1);
    fault(2, 1'b0, 3'h1, -1, 4'h0);
    check({31'h0, n == 400}, 32'h1);
    check({31'h0, lockout_active}, 32'h1);
    wait_idle();
    check(win(lo_len, TD * arseq_pkg::LOCKOUT_TICKS), 32'h1);
    fault(8, 1'b0, 3'h1, -1, 4'h0);
    check(win(n, TD * 5), 32'h1);
    wait_idle();
    done("lock-out");
    bus(1'b1, arseq_pkg::OFS_RECLAIM, 32'h0);
    bus(1'b1, arseq_pkg::OFS_CTRL, 32'h0000_0105);
    fault(8, 1'b0, 3'h1, -1, 4'h0);
    check(win(n, TD * 5), 32'h1);
    wait_idle();
    check(win(n, 0), 32'h1);
    done("adaptive");
    summarize();
  end
endmodule // auto_reclose_sequencer_tb

`default_nettype wire
